// [bench/ddr_mem_model.sv]
// Behavioural DDR/DDR2 memory that stands on the far side of the command engine.
// Assumes registered commands and data on core_clk, one word pair per clock.
`timescale 1ns/100ps
module ddr_mem_model
  import sdram_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire cfg_s cfg,
  input wire mem_cmd_s mem_cmd,
  input wire logic [BANK_W-1:0] mem_ba,
  input wire logic [ROW_W-1:0] mem_addr,
  input wire logic [2*DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [1:0] dqs_out,
  input wire logic bad_strobe,
  output logic [2*DQ_W-1:0] dq_in,
  output logic [1:0] dqs_in,
  output int proto_err
);
  logic [2*DQ_W-1:0] store [int]; // Stored pairs, keyed by bank and column.
  logic [NBANK-1:0] is_open; // Banks that hold an open row.
  int cyc, rd_t, wr_t, rd_left, wr_left, rd_key, wr_key;

  initial
  begin
    proto_err = 0;
    dq_in = '0;
    dqs_in = 2'h1;
  end

  // Serve pending beats first, then decode the command seen at this edge.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      is_open = '0;
      rd_left = 0;
      wr_left = 0;
      cyc = 0;
    end
    else
    begin
      cyc++;
      if (wr_left > 0 && cyc >= wr_t)
      begin
        if (dq_oe !== 1'b1 || dqs_out !== 2'h2) proto_err++;
        store[wr_key] = dq_out;
        wr_key++;
        wr_left--;
      end
      if (rd_left > 0 && cyc >= rd_t)
      begin
        dq_in <= store.exists(rd_key) ? store[rd_key] : '0;
        dqs_in <= bad_strobe ? 2'h3 : 2'h2;
        rd_key++;
        rd_left--;
      end
      else
      begin
        // A released bus must not keep showing the last pair.
        dq_in <= ~dq_in;
        dqs_in <= 2'h1;
      end
      if (mem_cmd == CMD_ACT)
      begin
        if (is_open[mem_ba]) proto_err++;
        is_open[mem_ba] = 1'b1;
      end
      if (mem_cmd == CMD_PRE) is_open[mem_ba] = 1'b0;
      if (mem_cmd == CMD_RD || mem_cmd == CMD_WR)
      begin
        if (!is_open[mem_ba]) proto_err++;
        rd_key = int'(mem_ba) * 1024 + int'(mem_addr[COL_W-1:0]);
        if (mem_cmd == CMD_RD)
        begin
          rd_left = (cfg.bl == BL_2) ? 1 : (cfg.bl == BL_4) ? 2 : 4;
          rd_t = cyc + int'(cfg.cl) + (cfg.ddr2 ? 0 : int'(cfg.cl_half)) - 1;
        end
        else
        begin
          wr_key = rd_key;
          wr_left = (cfg.bl == BL_2) ? 1 : (cfg.bl == BL_4) ? 2 : 4;
          wr_t = cyc + (cfg.ddr2 ? int'(cfg.cl) - 1 : 1);
        end
      end
    end
  end
endmodule : ddr_mem_model

// [bench/sdram_cmd_ctrl_bench.sv]
// Self-checking bench for the DDR/DDR2 command engine against a memory model.
// Assumes a 10 MHz core_clk and the engine's documented hand-over timing.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module sdram_cmd_ctrl_bench
  import sdram_cmd_pkg::*;
;
  logic core_clk, rst, req_valid, wr_valid, bad_strobe, saw_n_oe;
  logic cfg_err, req_ready, wr_ready, rd_valid, strobe_err, dq_oe, dqs_oe, dqs_n_oe;
  cfg_s cfg;
  req_s req;
  mem_cmd_s mem_cmd;
  logic [BANK_W-1:0] mem_ba;
  logic [ROW_W-1:0] mem_addr;
  logic [2*DQ_W-1:0] wr_data, rd_data, dq_out, dq_in;
  logic [1:0] dqs_out, dqs_n_out, dqs_in, odt_sel;
  int n_mismatch, n_checks, proto_err;
  mem_cmd_s cmd_q [$]; // Commands seen on the pins.
  logic [15:0] rd_q [$], wq [$]; // Read pairs seen and pairs expected.

  sdram_cmd_ctrl sdram_cmd_ctrl_inst (.core_clk(core_clk), .rst(rst), .cfg(cfg),
    .cfg_err(cfg_err), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .strobe_err(strobe_err), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .dqs_out(dqs_out),
    .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .dqs_n_oe(dqs_n_oe), .dqs_in(dqs_in),
    .odt_sel(odt_sel));
  ddr_mem_model ddr_mem_model_inst (.core_clk(core_clk), .rst(rst), .cfg(cfg),
    .mem_cmd(mem_cmd), .mem_ba(mem_ba), .mem_addr(mem_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_out(dqs_out), .bad_strobe(bad_strobe), .dq_in(dq_in),
    .dqs_in(dqs_in), .proto_err(proto_err));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Log pin activity; values before this edge's updates are taken.
  always @(posedge core_clk)
  begin
    if (!rst && mem_cmd !== CMD_NOP) cmd_q.push_back(mem_cmd);
    if (!rst && rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (dqs_n_oe === 1'b1)
    begin
      saw_n_oe = 1'b1;
      `CHK("complement strobe", 2'h1, dqs_n_out)
    end
  end

  function automatic cfg_s mk(input int d2, bl, cl, hf, df, pl, od);
    mk = cfg_s'{d2[0], bl[1:0], cl[2:0], hf[0], df[0], pl[0], od[1:0]};
  endfunction : mk

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Hold valid across all words, so it is never assigned twice in one step.
  task automatic push_n(input int cnt, input logic [15:0] base);
    int n;
    for (int i = 0; i < cnt; i++)
    begin
      wr_valid <= 1'b1;
      wr_data <= base + 16'(i);
      n = 0;
      @(negedge core_clk);
      while (wr_ready !== 1'b1 && n < 20)
      begin
        @(negedge core_clk);
        n++;
      end
      @(posedge core_clk);
      wq.push_back(base + 16'(i));
    end
    wr_valid <= 1'b0;
  endtask : push_n

  // Offer one access, then wait for the engine to come back to idle.
  task automatic issue(input logic wr, input int bank, row, col);
    int n;
    n = 0;
    req <= req_s'{wr, bank[BANK_W-1:0], row[ROW_W-1:0], col[COL_W-1:0]};
    req_valid <= 1'b1;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    req <= '0;
    n = 0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 80)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK("engine back to idle", 1'b1, req_ready)
    @(posedge core_clk);
  endtask : issue

  task automatic expect_reads(input int cnt);
    int n;
    logic [15:0] e;
    logic [15:0] g;
    n = 0;
    while (rd_q.size() < cnt && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK("read pair count", cnt, rd_q.size())
    while (rd_q.size() > 0 && wq.size() > 0)
    begin
      e = wq.pop_front();
      g = rd_q.pop_front();
      `CHK("read pair", e, g)
    end
    rd_q.delete();
    wq.delete();
  endtask : expect_reads

  task automatic chk_cmds(input mem_cmd_s e [$]);
    `CHK("command count", e.size(), cmd_q.size())
    foreach (e[i])
      if (i < cmd_q.size()) `CHK("command", e[i], cmd_q[i])
    cmd_q.delete();
  endtask : chk_cmds

  // Legal and illegal settings; an illegal one must also block requests.
  task automatic t_cfg_table;
    cfg_s tab [10];
    logic [9:0] bad;
    tab = '{mk(0,3,2,0,0,0,0), mk(0,0,2,0,0,0,0), mk(0,1,4,0,0,0,0), mk(0,1,2,1,0,0,0),
      mk(1,0,3,0,0,0,0), mk(1,2,5,0,1,0,0), mk(1,1,6,0,0,0,0), mk(1,1,3,1,0,0,0),
      mk(1,2,3,0,0,1,0), mk(0,1,3,0,0,1,0)};
    bad = 10'b0111010101;
    for (int i = 0; i < 10; i++)
    begin
      cfg <= tab[i];
      @(negedge core_clk);
      `CHK("config error", bad[i], cfg_err)
      `CHK("ready under config", ~bad[i], req_ready)
      @(posedge core_clk);
    end
  endtask : t_cfg_table

  task automatic t_ddr2_rw;
    cfg <= mk(1, 1, 3, 0, 1, 0, 2);
    saw_n_oe = 1'b0;
    push_n(2, 16'ha100);
    issue(1'b1, 1, 5, 8);
    issue(1'b0, 1, 5, 8);
    expect_reads(2);
    chk_cmds('{CMD_ACT, CMD_WR, CMD_RD});
    wq = '{16'ha100, 16'ha101};
    issue(1'b0, 1, 6, 8);
    expect_reads(2);
    chk_cmds('{CMD_PRE, CMD_ACT, CMD_RD});
    `CHK("differential strobe", 1'b1, saw_n_oe)
    `CHK("termination select", 2'h2, odt_sel)
    `CHK("memory side faults", 0, proto_err)
  endtask : t_ddr2_rw

  // Fill the buffer until it refuses, then drain it with two long bursts.
  task automatic t_ddr_fifo;
    cfg <= mk(0, 2, 2, 1, 0, 0, 1);
    saw_n_oe = 1'b0;
    push_n(8, 16'hb000);
    @(negedge core_clk);
    `CHK("buffer full", 1'b0, wr_ready)
    @(posedge core_clk);
    issue(1'b1, 2, 3, 0);
    issue(1'b1, 3, 3, 0);
    `CHK("buffer drained", 1'b1, wr_ready)
    issue(1'b0, 2, 3, 0);
    issue(1'b0, 3, 3, 0);
    expect_reads(8);
    chk_cmds('{CMD_ACT, CMD_WR, CMD_ACT, CMD_WR, CMD_RD, CMD_RD});
    `CHK("single strobe", 1'b0, saw_n_oe)
    `CHK("termination off", 2'h0, odt_sel)
    req <= req_s'{1'b0, 3'h4, 14'h0000, 10'h000};
    req_valid <= 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK("fifth bank refused", 1'b0, req_ready)
    @(posedge core_clk);
    req_valid <= 1'b0;
    `CHK("no command issued", 0, cmd_q.size())
    `CHK("memory side faults ddr", 0, proto_err)
  endtask : t_ddr_fifo

  // Bad read strobe, then a mid-run reset must clear it and the open rows.
  task automatic t_strobe;
    cfg <= mk(1, 1, 2, 0, 0, 0, 3);
    bad_strobe <= 1'b1;
    issue(1'b0, 4, 1, 0);
    repeat (6) @(posedge core_clk);
    `CHK("strobe fault", 1'b1, strobe_err)
    chk_cmds('{CMD_ACT, CMD_RD});
    rst <= 1'b1;
    bad_strobe <= 1'b0;
    repeat (12) @(posedge core_clk);
    `CHK("strobe fault cleared", 1'b0, strobe_err)
    `CHK("odt in reset", 2'h0, odt_sel)
    rst <= 1'b0;
    rd_q.delete();
    @(posedge core_clk);
    issue(1'b0, 1, 5, 8);
    wq = '{16'ha100, 16'ha101};
    expect_reads(2);
    chk_cmds('{CMD_ACT, CMD_RD});
  endtask : t_strobe

  initial
  begin
    #2000000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    wr_valid = 1'b0;
    wr_data = '0;
    req = '0;
    bad_strobe = 1'b0;
    saw_n_oe = 1'b0;
    cfg = mk(1, 1, 3, 0, 1, 0, 2);
    repeat (12) @(posedge core_clk);
    `CHK("command in reset", CMD_NOP, mem_cmd)
    `CHK("data drive in reset", 1'b0, dq_oe)
    rst <= 1'b0;
    @(posedge core_clk);
    t_cfg_table();
    t_ddr2_rw();
    t_ddr_fifo();
    t_strobe();
    summarize();
  end
endmodule : sdram_cmd_ctrl_bench

// [hdl/burst_fifo.sv]
// Write data FIFO with valid/ready on both ends and a fill level.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module burst_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  // Storage words; the head word is read straight from these flops.
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;

  // Data words are written without reset since only counted words are read.
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : burst_fifo

// [hdl/sdram_cmd_ctrl.sv]
// Command and burst engine for DDR or DDR2 SDRAM, one access at a time.
// Assumes the memory clock is core_clk; each cycle carries a rise/fall word pair.
// How it works
// - DDR moves two words per clock, 2n prefetch.
// - DDR bursts are 2, 4 or 8 beats.
// - DDR read latency is 2, 2.5 or 3.
// - One shared address bus for reads and writes.
// - Strobe and data bidirectional, strobe owns its group.
// - DDR2 prefetches four words, two transfers per clock.
// - DDR2 strobe single or differential; DDR single only.
// - DDR2 bursts are 4 or 8 beats.
// - DDR2 read latency 2 to 5, no halves.
// - Reads edge-aligned, writes center-aligned to strobe.
`timescale 1ns/100ps
module sdram_cmd_ctrl
  import sdram_cmd_pkg::*;
#(
  parameter int MEM_CLK_MHZ = CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire cfg_s cfg,
  output logic cfg_err,
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [2*DQ_W-1:0] wr_data,
  output logic [2*DQ_W-1:0] rd_data,
  output logic rd_valid,
  output logic strobe_err,
  output mem_cmd_s mem_cmd,
  output logic [BANK_W-1:0] mem_ba,
  output logic [ROW_W-1:0] mem_addr,
  output logic [2*DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [2*DQ_W-1:0] dq_in,
  output logic [1:0] dqs_out,
  output logic [1:0] dqs_n_out,
  output logic dqs_oe,
  output logic dqs_n_oe,
  input wire logic [1:0] dqs_in,
  output logic [1:0] odt_sel
);

  typedef enum {S_IDLE, S_WAIT_RP, S_WAIT_RCD, S_DATA} state_e;

  // Clock cycles (word pairs) per burst for the configured length.
  function automatic logic [2:0] burst_pairs(input logic [1:0] bl);
    return (bl == BL_2) ? 3'h1 : (bl == BL_4) ? 3'h2 : 3'h4;
  endfunction : burst_pairs

  // Whole-clock read latency; a half setting is sampled one half later.
  function automatic logic [3:0] cas_whole(input cfg_s c);
    return {1'b0, c.cl} + {3'h0, c.cl_half & ~c.ddr2};
  endfunction : cas_whole

  state_e state_reg;
  req_s req_reg; // Request in service.
  logic [ROW_W-1:0] open_row_reg [NBANK]; // Open row per bank.
  logic [NBANK-1:0] open_vld_reg; // Bank holds an open row.
  logic [1:0] timer_reg; // Wait between row commands.
  logic [3:0] lat_reg; // Cycles left before the data phase.
  logic [2:0] beat_reg; // Word pairs left in the burst.
  logic [2*DQ_W-1:0] dq_sync1_reg;
  logic [2*DQ_W-1:0] dq_sync2_reg;
  logic [1:0] dqs_sync1_reg;
  logic [1:0] dqs_sync2_reg;
  logic [2*DQ_W-1:0] fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic fifo_valid;
  logic hit;
  logic beat;
  logic wr_beat;
  logic rd_beat;
  logic accept;
  logic act_clash;

  // Write data waits here so a burst never runs dry once started.
  burst_fifo #(.WIDTH(2 * DQ_W), .DEPTH(FIFO_DEPTH)) wr_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(wr_beat),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // Illegal settings block all new requests until corrected.
  always_comb
  begin
    cfg_err = 1'b0;
    if (!cfg.ddr2)
    begin
      if (cfg.bl == 2'h3) cfg_err = 1'b1;
      if (cfg.cl < DDR_CL_MIN || cfg.cl > DDR_CL_MAX) cfg_err = 1'b1;
      if (cfg.cl == DDR_CL_MAX && cfg.cl_half) cfg_err = 1'b1;
      if (MEM_CLK_MHZ > DDR_FMAX_MHZ || 2 * MEM_CLK_MHZ > DDR_MBPS_MAX) cfg_err = 1'b1;
    end
    else
    begin
      if (cfg.bl != BL_4 && cfg.bl != BL_8) cfg_err = 1'b1;
      if (cfg.cl < DDR2_CL_MIN || cfg.cl > DDR2_CL_MAX || cfg.cl_half) cfg_err = 1'b1;
      if (MEM_CLK_MHZ > DDR2_FMAX_MHZ) cfg_err = 1'b1;
    end
    if (cfg.phy_lite && cfg.bl == BL_8) cfg_err = 1'b1;
  end

  // A request is taken only when idle, legal, and, for a write, fully buffered.
  assign hit = open_vld_reg[req.bank] && (open_row_reg[req.bank] == req.row);
  assign req_ready = (state_reg == S_IDLE) && !cfg_err &&
                     (cfg.ddr2 || req.bank < BANK_W'(DDR_NBANK)) &&
                     (!req.wr || fifo_level >= {1'b0, burst_pairs(cfg.bl)});
  assign accept = req_valid && req_ready;
  assign beat = (state_reg == S_DATA) && (lat_reg == 4'h0);
  assign wr_beat = beat && req_reg.wr;
  assign rd_beat = beat && !req_reg.wr;

  // Pin inputs cross two flops before any logic looks at them.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_sync1_reg <= '0;
      dq_sync2_reg <= '0;
      dqs_sync1_reg <= '0;
      dqs_sync2_reg <= '0;
    end
    else
    begin
      dq_sync1_reg <= dq_in;
      dq_sync2_reg <= dq_sync1_reg;
      dqs_sync1_reg <= dqs_in;
      dqs_sync2_reg <= dqs_sync1_reg;
    end
  end

  // Sequencer: only one access in flight, so banks are never interleaved
  // and no additive latency is ever applied to a column command.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      req_reg <= '0;
      timer_reg <= '0;
      lat_reg <= '0;
      beat_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (accept)
          begin
            req_reg <= req;
            beat_reg <= burst_pairs(cfg.bl);
            if (hit)
            begin
              state_reg <= S_DATA;
              lat_reg <= req.wr ? (cfg.ddr2 ? cas_whole(cfg) - 4'h2 : 4'h0)
                                : cas_whole(cfg) + 4'(SYNC_STAGES);
            end
            else if (open_vld_reg[req.bank])
            begin
              state_reg <= S_WAIT_RP;
              timer_reg <= 2'(T_RP_CYC - 1);
            end
            else
            begin
              state_reg <= S_WAIT_RCD;
              timer_reg <= 2'(T_RCD_CYC - 1);
            end
          end
        end
        S_WAIT_RP:
        begin
          // The bank closes, then the wanted row opens.
          if (timer_reg == 2'h0)
          begin
            state_reg <= S_WAIT_RCD;
            timer_reg <= 2'(T_RCD_CYC - 1);
          end
          else timer_reg <= timer_reg - 2'h1;
        end
        S_WAIT_RCD:
        begin
          if (timer_reg == 2'h0)
          begin
            state_reg <= S_DATA;
            lat_reg <= req_reg.wr ? (cfg.ddr2 ? cas_whole(cfg) - 4'h2 : 4'h0)
                                  : cas_whole(cfg) + 4'(SYNC_STAGES);
          end
          else timer_reg <= timer_reg - 2'h1;
        end
        S_DATA:
        begin
          if (lat_reg != 4'h0) lat_reg <= lat_reg - 4'h1;
          else if (beat_reg == 3'h1) state_reg <= S_IDLE;
          else beat_reg <= beat_reg - 3'h1;
        end
      endcase
    end
  end

  // Open-row table: one open row per bank at most.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      open_vld_reg <= '0;
      for (int i = 0; i < NBANK; i++) open_row_reg[i] <= '0;
    end
    else if (state_reg == S_IDLE && accept && !hit && !open_vld_reg[req.bank])
    begin
      // A closed bank opens with the row of the request just taken.
      open_vld_reg[req.bank] <= 1'b1;
      open_row_reg[req.bank] <= req.row;
    end
    else if (state_reg == S_WAIT_RP && timer_reg == 2'h0)
    begin
      // Only the bank of the access in service is touched, never one left
      // over in the request register from an earlier access or from reset.
      open_vld_reg[req_reg.bank] <= 1'b1;
      open_row_reg[req_reg.bank] <= req_reg.row;
    end
  end

  // Command pins: one shared bank/address bus for every command kind.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_cmd <= CMD_NOP;
      mem_ba <= '0;
      mem_addr <= '0;
    end
    else
    begin
      mem_cmd <= CMD_NOP;
      if (accept && hit)
      begin
        mem_cmd <= req.wr ? CMD_WR : CMD_RD;
        mem_ba <= req.bank;
        mem_addr <= ROW_W'(req.col) & ~(ROW_W'(1) << AP_BIT);
      end
      else if (accept)
      begin
        mem_cmd <= open_vld_reg[req.bank] ? CMD_PRE : CMD_ACT;
        mem_ba <= req.bank;
        mem_addr <= open_vld_reg[req.bank] ? '0 : req.row;
      end
      else if (state_reg == S_WAIT_RP && timer_reg == 2'h0)
      begin
        mem_cmd <= CMD_ACT;
        mem_addr <= req_reg.row;
      end
      else if (state_reg == S_WAIT_RCD && timer_reg == 2'h0)
      begin
        mem_cmd <= req_reg.wr ? CMD_WR : CMD_RD;
        mem_addr <= ROW_W'(req_reg.col) & ~(ROW_W'(1) << AP_BIT);
      end
    end
  end

  // Write side: a rise/fall word pair per clock, strobe high then low so
  // each strobe edge sits mid-bit of the quarter-shifted data.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      dqs_out <= 2'h0;
      dqs_oe <= 1'b0;
      dqs_n_oe <= 1'b0;
    end
    else
    begin
      dq_oe <= wr_beat;
      dqs_oe <= wr_beat;
      dqs_n_oe <= wr_beat && cfg.ddr2 && cfg.diff_dqs;
      dqs_out <= wr_beat ? 2'h2 : 2'h0;
      if (wr_beat && fifo_valid) dq_out <= fifo_data;
    end
  end
  assign dqs_n_out = ~dqs_out;

  // Read side: capture a pair per clock; a missing strobe pattern is flagged.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      strobe_err <= 1'b0;
      odt_sel <= ODT_OFF;
    end
    else
    begin
      rd_valid <= rd_beat && (dqs_sync2_reg == 2'h2);
      if (rd_beat) rd_data <= dq_sync2_reg;
      if (rd_beat && dqs_sync2_reg != 2'h2) strobe_err <= 1'b1;
      odt_sel <= cfg.ddr2 ? cfg.odt_sel : ODT_OFF;
    end
  end

  property p_lite_no_bl8;
    @(posedge core_clk) disable iff (rst) (cfg.phy_lite && cfg.bl == BL_8) |-> !req_ready;
  endproperty
  a_lite_no_bl8: assert property (p_lite_no_bl8) else $error("eight-beat burst in lite mode");

  property p_ddr_single_strobe;
    @(posedge core_clk) disable iff (rst) !cfg.ddr2 |-> !dqs_n_oe;
  endproperty
  a_ddr_single_strobe: assert property (p_ddr_single_strobe) else $error("ddr diff strobe");

  property p_ddr_wl;
    @(posedge core_clk) disable iff (rst) (mem_cmd == CMD_WR && !cfg.ddr2) |-> ##1 dq_oe;
  endproperty
  a_ddr_wl: assert property (p_ddr_wl) else $error("ddr write latency not one");

  property p_ddr2_wl;
    @(posedge core_clk) disable iff (rst)
      (mem_cmd == CMD_WR && cfg.ddr2 && cfg.cl == 3'h3) |-> !dq_oe ##1 !dq_oe ##1 dq_oe;
  endproperty
  a_ddr2_wl: assert property (p_ddr2_wl) else $error("ddr2 write latency wrong");

  property p_burst4;
    @(posedge core_clk) disable iff (rst)
      ($rose(dq_oe) && cfg.bl == BL_4) |-> ##1 dq_oe ##1 !dq_oe;
  endproperty
  a_burst4: assert property (p_burst4) else $error("four-beat burst length wrong");

  property p_rd_cl3;
    @(posedge core_clk) disable iff (rst)
      (mem_cmd == CMD_RD && cfg.cl == 3'h3 && !cfg.cl_half) |-> !rd_beat [*5] ##1 rd_beat;
  endproperty
  a_rd_cl3: assert property (p_rd_cl3) else $error("read capture time wrong");

  property p_pre_then_act;
    @(posedge core_clk) disable iff (rst) (mem_cmd == CMD_PRE) |-> ##[1:4] (mem_cmd == CMD_ACT);
  endproperty
  a_pre_then_act: assert property (p_pre_then_act) else $error("no activate after precharge");

  property p_act_closed_bank;
    @(posedge core_clk) disable iff (rst)
      (mem_cmd == CMD_ACT) |-> $past(mem_cmd) != CMD_RD && $past(mem_cmd) != CMD_WR;
  endproperty
  a_act_closed_bank: assert property (p_act_closed_bank) else $error("activate on busy bank");

  property p_strobe_with_data;
    @(posedge core_clk) disable iff (rst) dq_oe == dqs_oe;
  endproperty
  a_strobe_with_data: assert property (p_strobe_with_data) else $error("strobe off its data");

  c_write: cover property (@(posedge core_clk) disable iff (rst) $rose(dq_oe));
  c_read: cover property (@(posedge core_clk) disable iff (rst) rd_valid);
  c_miss: cover property (@(posedge core_clk) disable iff (rst) mem_cmd == CMD_PRE);

endmodule : sdram_cmd_ctrl

// [hdl/sdram_cmd_pkg.sv]
// Shared types and constants for the DDR/DDR2 command and burst logic.
// Assumes one memory-side clock; all users import the whole package.
package sdram_cmd_pkg;

  // Sizes of the address fields, bank counts, data width, write buffer depth and input sync stages.
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int BANK_W = 3;
  localparam int NBANK = 8;
  localparam int DDR_NBANK = 4;
  localparam int DQ_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;

  // Position of the auto-precharge bit in a column address.
  localparam int AP_BIT = 10;

  // Clock rate and the timing figures that follow from it.
  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int T_RP_NS = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Highest memory clock per mode, and the DDR per-pin rate.
  localparam int DDR_FMAX_MHZ = 200;
  localparam int DDR_MBPS_MAX = 400;
  localparam int DDR2_FMAX_MHZ = 533;

  // Burst length codes, legal latency limits and the termination-off code.
  localparam logic [1:0] BL_2 = 2'h0;
  localparam logic [1:0] BL_4 = 2'h1;
  localparam logic [1:0] BL_8 = 2'h2;
  localparam logic [2:0] DDR_CL_MIN = 3'h2;
  localparam logic [2:0] DDR_CL_MAX = 3'h3;
  localparam logic [2:0] DDR2_CL_MIN = 3'h2;
  localparam logic [2:0] DDR2_CL_MAX = 3'h5;
  localparam logic [1:0] ODT_OFF = 2'h0;

  // Command encodings as {ras_n, cas_n, we_n}.
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
  } mem_cmd_s;
  localparam mem_cmd_s CMD_NOP = 3'h7;
  localparam mem_cmd_s CMD_ACT = 3'h3;
  localparam mem_cmd_s CMD_RD = 3'h5;
  localparam mem_cmd_s CMD_WR = 3'h4;
  localparam mem_cmd_s CMD_PRE = 3'h2;

  // One user access request.
  typedef struct packed {
    logic wr;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } req_s;

  // Static configuration, held steady while traffic runs.
  typedef struct packed {
    logic ddr2;
    logic [1:0] bl;
    logic [2:0] cl;
    logic cl_half;
    logic diff_dqs;
    logic phy_lite;
    logic [1:0] odt_sel;
  } cfg_s;

endpackage : sdram_cmd_pkg
